// [hw/adc_fmt_pkg.sv]
// constants for the converter output formatter
// assumes a single 100 MHz reference clock domain
package adc_fmt_pkg;
    // ********************************
    // clock and widths
    // ********************************
    localparam int          REF_CLK_MHZ  = 100;
    localparam int          REF_PER_PS   = 1000000 / REF_CLK_MHZ;
    localparam int          WORD_W       = 10;
    localparam int          NUM_STAGES   = 9;
    localparam int          STAGE_W      = 2;
    localparam int          SUM_W        = 12;
    // ********************************
    // pipeline and coding
    // ********************************
    localparam int          LATENCY      = 9;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          TICK_CNT_W   = 4;
    localparam logic [11:0] CORR_OFFSET  = 12'h00ff;
    localparam logic [9:0]  CODE_POS_FS  = 10'h03ff;
    localparam logic [9:0]  CODE_NEG_FS  = 10'h0000;
    localparam logic [9:0]  WORD_RST     = 10'h0000;
    localparam logic        FMT_TWOS     = 1'b0;
    localparam logic        HALVE_ON     = 1'b0;
endpackage

// [hw/adc_fmt_fifo.sv]
// small word buffer with valid and ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module adc_fmt_fifo #(
    parameter int W     = 11,
    parameter int DEPTH = 8
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_arst_n,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [W-1:0]  mem_r [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] cnt_r;
    logic          out_valid_r;
    logic [W-1:0]  out_data_r;

    wire do_wr   = i_in_valid && o_in_ready;
    wire load_out = (cnt_r != '0) && (!out_valid_r || i_out_ready);

    assign o_in_ready  = (cnt_r != FULL_CNT);
    assign o_out_valid = out_valid_r;
    assign o_out_data  = out_data_r;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == LAST_PTR) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge i_ref_clk) begin
        if (do_wr) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            cnt_r       <= '0;
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (load_out) begin
                rd_ptr_r   <= ptr_inc(rd_ptr_r);
                out_data_r <= mem_r[rd_ptr_r];
            end
            if (load_out) begin
                out_valid_r <= 1'b1;
            end else if (i_out_ready) begin
                out_valid_r <= 1'b0;
            end
            cnt_r <= CW'(cnt_r + {{(CW-1){1'b0}}, do_wr} - {{(CW-1){1'b0}}, load_out});
        end
    end
endmodule

// [hw/adc_fmt_top.sv]
// digital output side of a 10-bit pipelined converter
// assumes stage codes settle before each sampling clock edge
`timescale 1ns/1ps
module adc_fmt_top #(
    parameter int WORD_W     = adc_fmt_pkg::WORD_W,
    parameter int NUM_STAGES = adc_fmt_pkg::NUM_STAGES,
    parameter int LATENCY    = adc_fmt_pkg::LATENCY,
    parameter int FIFO_DEPTH = adc_fmt_pkg::FIFO_DEPTH
) (
    input  wire logic                               i_ref_clk,
    input  wire logic                               i_arst_n,
    input  wire logic                               i_sample_clock_true,
    input  wire logic                               i_sample_clock_comp,
    input  wire logic [NUM_STAGES*adc_fmt_pkg::STAGE_W-1:0] i_stage_code,
    input  wire logic                               i_format_sel,
    input  wire logic                               i_clock_halve_ctrl,
    input  wire logic                               i_rx_ready,
    output logic [WORD_W-1:0]                       o_sample_word_true,
    output logic [WORD_W-1:0]                       o_sample_word_comp,
    output logic                                    o_fwd_clock_true,
    output logic                                    o_fwd_clock_comp,
    output logic                                    o_range_flag_true,
    output logic                                    o_range_flag_comp,
    output logic                                    o_buf_ready,
    output logic                                    o_word_lost
);
    localparam int SC_W = NUM_STAGES * adc_fmt_pkg::STAGE_W;
    localparam int SW   = adc_fmt_pkg::SUM_W;
    localparam int TW   = adc_fmt_pkg::TICK_CNT_W;
    localparam logic [TW-1:0] LAT_CNT = TW'(LATENCY);

    // ********************************
    // pin synchronisers
    // ********************************
    logic [3:0]      pin_meta_r;
    logic [3:0]      pin_sync_r;
    logic [SC_W-1:0] code_meta_r;
    logic [SC_W-1:0] code_sync_r;
    logic            clk_true_d_r;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_meta_r   <= 4'h0;
            pin_sync_r   <= 4'h0;
            code_meta_r  <= '0;
            code_sync_r  <= '0;
            clk_true_d_r <= 1'b0;
        end else begin
            pin_meta_r   <= {i_sample_clock_true, i_sample_clock_comp,
                             i_format_sel, i_clock_halve_ctrl};
            pin_sync_r   <= pin_meta_r;
            code_meta_r  <= i_stage_code;
            code_sync_r  <= code_meta_r;
            clk_true_d_r <= pin_sync_r[3];
        end
    end

    wire clk_true_s = pin_sync_r[3];
    wire clk_comp_s = pin_sync_r[2];
    // open pins are pulled low outside; a low level here means twos complement
    wire fmt_bin_s  = pin_sync_r[1];
    wire full_rate  = pin_sync_r[0];

    // rising true leg while the complementary leg is low
    wire edge_pulse = clk_true_s && !clk_true_d_r && !clk_comp_s;

    // ********************************
    // clock halving
    // ********************************
    logic half_phase_r;
    wire  conv_tick = edge_pulse && (full_rate || half_phase_r);

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            half_phase_r <= 1'b1;
        end else if (edge_pulse) begin
            half_phase_r <= full_rate ? 1'b1 : !half_phase_r;
        end
    end

    // ********************************
    // digital correction
    // ********************************
    function automatic logic [SW-1:0] stage_sum(input logic [SC_W-1:0] c);
        logic [SW-1:0] acc;
        acc = '0;
        for (int k = 0; k < NUM_STAGES; k++) begin
            acc = SW'(acc + (SW'(c[SC_W-1-2*k -: 2]) << (NUM_STAGES - 1 - k)));
        end
        return acc;
    endfunction

    wire signed [SW-1:0] corr_val  = signed'(SW'(stage_sum(code_sync_r)
                                     - adc_fmt_pkg::CORR_OFFSET));
    wire signed [SW-1:0] pos_lim   = signed'(SW'(adc_fmt_pkg::CODE_POS_FS));
    wire                 over_pos  = corr_val > pos_lim;
    wire                 under_neg = corr_val < 0;
    wire                 corr_or   = over_pos || under_neg;
    wire [WORD_W-1:0]    corr_bin  = over_pos  ? adc_fmt_pkg::CODE_POS_FS :
                                     under_neg ? adc_fmt_pkg::CODE_NEG_FS :
                                     corr_val[WORD_W-1:0];

    // ********************************
    // latency line
    // ********************************
    logic [WORD_W:0] line_r [0:LATENCY-1];
    logic [TW-1:0]   tick_cnt_r;
    wire             line_full = (tick_cnt_r >= LAT_CNT);

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < LATENCY; i++) begin
                line_r[i] <= '0;
            end
            tick_cnt_r <= '0;
        end else if (conv_tick) begin
            line_r[0] <= {corr_or, corr_bin};
            for (int i = 1; i < LATENCY; i++) begin
                line_r[i] <= line_r[i-1];
            end
            if (!line_full) begin
                tick_cnt_r <= TW'(tick_cnt_r + 1'b1);
            end
        end
    end

    // ********************************
    // output buffer
    // ********************************
    wire              push     = conv_tick && line_full;
    wire              fifo_in_ready;
    wire              fifo_vld;
    wire [WORD_W:0]   fifo_dout;
    logic             upd_r;
    wire              present  = fifo_vld && i_rx_ready && !upd_r;

    adc_fmt_fifo #(
        .W     (WORD_W + 1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (line_r[LATENCY-1]),
        .o_out_valid (fifo_vld),
        .i_out_ready (present),
        .o_out_data  (fifo_dout)
    );

    // ********************************
    // output stage
    // ********************************
    wire [WORD_W-1:0] twos_word = {!fifo_dout[WORD_W-1], fifo_dout[WORD_W-2:0]};
    wire [WORD_W-1:0] word_nxt  = fmt_bin_s ? fifo_dout[WORD_W-1:0] : twos_word;

    logic [WORD_W-1:0] word_r;
    logic [WORD_W-1:0] word_comp_r;
    logic              or_r;
    logic              or_comp_r;
    logic              fwd_r;
    logic              fwd_comp_r;
    logic              lost_r;
    logic              buf_rdy_r;

    // the word changes with the forwarded clock low and is latched on its next rise
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            word_r      <= adc_fmt_pkg::WORD_RST;
            word_comp_r <= ~adc_fmt_pkg::WORD_RST;
            or_r        <= 1'b0;
            or_comp_r   <= 1'b1;
            upd_r       <= 1'b0;
            fwd_r       <= 1'b0;
            fwd_comp_r  <= 1'b1;
            lost_r      <= 1'b0;
            buf_rdy_r   <= 1'b1;
        end else begin
            if (present) begin
                word_r      <= word_nxt;
                word_comp_r <= ~word_nxt;
                or_r        <= fifo_dout[WORD_W];
                or_comp_r   <= !fifo_dout[WORD_W];
            end
            // rise one cycle after the word moved, so the receiver never races it
            upd_r      <= present;
            fwd_r      <= upd_r;
            fwd_comp_r <= !upd_r;
            lost_r     <= lost_r || (push && !fifo_in_ready);
            buf_rdy_r  <= fifo_in_ready;
        end
    end

    assign o_sample_word_true = word_r;
    assign o_sample_word_comp = word_comp_r;
    assign o_fwd_clock_true   = fwd_r;
    assign o_fwd_clock_comp   = fwd_comp_r;
    assign o_range_flag_true  = or_r;
    assign o_range_flag_comp  = or_comp_r;
    assign o_buf_ready        = buf_rdy_r;
    assign o_word_lost        = lost_r;

    // ********************************
    // checks
    // ********************************
    logic last_ticked_r;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // the first divided edge converts, so history starts as a skip
            last_ticked_r <= 1'b0;
        end else if (edge_pulse) begin
            last_ticked_r <= conv_tick;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    sample_edge_a: assert property (edge_pulse |-> clk_true_s && !clk_comp_s
                                    && !$past(clk_true_s))
        else $error("sample taken without rising sampling clock");
    latency_fill_a: assert property (push |-> tick_cnt_r == LAT_CNT)
        else $error("word left latency line early");
    fwd_rise_a: assert property (present |=> !fwd_r ##1 fwd_r ##1 !fwd_r)
        else $error("forwarded clock did not rise after word update");
    word_stable_a: assert property (fwd_r |-> $stable(word_r))
        else $error("word changed on forwarded clock rise");
    format_code_a: assert property (present |=> word_r[WORD_W-1] ==
                                    ($past(fifo_dout[WORD_W-1]) ^ !$past(fmt_bin_s)))
        else $error("output format bit wrong");
    low_bits_a: assert property (present |=> word_r[WORD_W-2:0] ==
                                 $past(fifo_dout[WORD_W-2:0]))
        else $error("low bits altered by format");
    code_saturate_a: assert property (edge_pulse && corr_or |->
                                 corr_bin == adc_fmt_pkg::CODE_POS_FS ||
                                 corr_bin == adc_fmt_pkg::CODE_NEG_FS)
        else $error("out of range code not saturated");
    range_pair_a: assert property (o_range_flag_true != o_range_flag_comp)
        else $error("range flag legs not complementary");
    range_flag_a: assert property (present |=> or_r == $past(fifo_dout[WORD_W]))
        else $error("range flag not carried with word");
    half_rate_a: assert property (edge_pulse && full_rate == adc_fmt_pkg::HALVE_ON
                                  && $past(full_rate, 3) == adc_fmt_pkg::HALVE_ON
                                  |-> conv_tick != last_ticked_r)
        else $error("divided mode did not skip alternate edges");
    full_rate_a: assert property (edge_pulse && full_rate |-> conv_tick)
        else $error("full rate mode skipped an edge");

    // ********************************
    // checks on correction and latency
    // ********************************
    pos_sat_a: assert property (edge_pulse && over_pos
                                |-> corr_bin == adc_fmt_pkg::CODE_POS_FS)
        else $error("positive overrange not clamped");
    neg_sat_a: assert property (edge_pulse && under_neg
                                |-> corr_bin == adc_fmt_pkg::CODE_NEG_FS)
        else $error("negative overrange not clamped");
    in_range_a: assert property (edge_pulse && !corr_or
                                 |-> corr_bin == corr_val[WORD_W-1:0])
        else $error("in range code altered");
    line_head_a: assert property (conv_tick
                                  |=> line_r[0] == {$past(corr_or), $past(corr_bin)})
        else $error("corrected word not entered into latency line");
    tick_count_a: assert property (conv_tick && !line_full
                                   |=> tick_cnt_r == TW'($past(tick_cnt_r) + 1'b1))
        else $error("latency fill count skipped a tick");
    line_idle_a: assert property (!conv_tick
                                  |=> $stable(line_r[LATENCY-1]) && $stable(tick_cnt_r))
        else $error("latency line moved without a conversion");

    // ********************************
    // checks on the output legs
    // ********************************
    word_pair_a: assert property (o_sample_word_comp
                                  == ~o_sample_word_true)
        else $error("word legs not complementary");
    fwd_pair_a: assert property (o_fwd_clock_true
                                 != o_fwd_clock_comp)
        else $error("forwarded clock legs not complementary");
    fwd_pulse_a: assert property (fwd_r
                                  |=> !fwd_r)
        else $error("forwarded clock high for more than one cycle");
    word_hold_a: assert property (!present
                                  |=> $stable(word_r) && $stable(word_comp_r))
        else $error("word moved without an update");
    range_hold_a: assert property (!present
                                   |=> $stable(or_r) && $stable(or_comp_r))
        else $error("range flag moved without an update");
endmodule

// [dv/adc_rx_model.sv]
// receiver model: latches the output word and range flag on the forwarded clock
// assumes the bench reads got_q by hierarchical reference and drives i_stall
`timescale 1ns/1ps
module adc_rx_model (
    input  wire logic       i_fwd_clock_true,
    input  wire logic [9:0] i_word_true,
    input  wire logic [9:0] i_word_comp,
    input  wire logic       i_flag_true,
    input  wire logic       i_flag_comp,
    input  wire logic       i_stall,
    output logic            o_ready
);
    // ********************************
    // capture
    // ********************************
    logic [21:0] got_q[$];

    // a slow receiver simply withholds ready
    assign o_ready = ~i_stall;

    always @(posedge i_fwd_clock_true) begin
        got_q.push_back({i_flag_comp, i_flag_true, i_word_comp, i_word_true});
    end
endmodule

// [dv/adc_lvds_output_formatter_bench.sv]
// self-checking bench for the converter output formatter
// assumes a 100 MHz reference clock and the receiver model adc_rx_model
`timescale 1ns/1ps
module adc_lvds_output_formatter_bench;
    // ********************************
    // signals
    // ********************************
    logic        i_ref_clk = 1'b0;
    logic        i_arst_n  = 1'b0;
    logic        clk_t     = 1'b0;
    logic        clk_c     = 1'b1;
    logic [17:0] code      = 18'h0_0000;
    logic        fmt       = 1'b0;
    logic        halve     = 1'b0;
    logic        stall     = 1'b0;
    logic        rx_ready;
    logic [9:0]  word_t;
    logic [9:0]  word_c;
    logic        fwd_t;
    logic        fwd_c;
    logic        flag_t;
    logic        flag_c;
    logic        buf_ready;
    logic        lost;
    int          bad_count = 0;
    int          n_tests   = 0;
    logic [21:0] exp_q[$];

    always #5 i_ref_clk = ~i_ref_clk;

    adc_fmt_top dut_u (
        .i_ref_clk          (i_ref_clk),
        .i_arst_n           (i_arst_n),
        .i_sample_clock_true(clk_t),
        .i_sample_clock_comp(clk_c),
        .i_stage_code       (code),
        .i_format_sel       (fmt),
        .i_clock_halve_ctrl (halve),
        .i_rx_ready         (rx_ready),
        .o_sample_word_true (word_t),
        .o_sample_word_comp (word_c),
        .o_fwd_clock_true   (fwd_t),
        .o_fwd_clock_comp   (fwd_c),
        .o_range_flag_true  (flag_t),
        .o_range_flag_comp  (flag_c),
        .o_buf_ready        (buf_ready),
        .o_word_lost        (lost)
    );

    adc_rx_model rx_u (
        .i_fwd_clock_true(fwd_t),
        .i_word_true     (word_t),
        .i_word_comp     (word_c),
        .i_flag_true     (flag_t),
        .i_flag_comp     (flag_c),
        .i_stall         (stall),
        .o_ready         (rx_ready)
    );

    // ********************************
    // tasks
    // ********************************
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic [17:0] pick(input int i);
        logic [17:0] tbl [7];
        // full scale, zero, midscale, both edges of the upper limit, then corrected codes 256 and 255
        tbl = '{18'h3_ffff, 18'h0_0000, 18'h2_5555, 18'h3_d554,
                18'h3_d555, 18'h1_5555, 18'h1_5554};
        if (i < 7)
            return tbl[i];
        return 18'(i * 32'h0000_2c47 + 32'h0000_1234);
    endfunction

    function automatic logic [21:0] expect_word(input logic [17:0] c, input logic f);
        int         s;
        logic [9:0] w;
        logic       fl;
        s = -int'(adc_fmt_pkg::CORR_OFFSET);
        for (int k = 0; k < 9; k++)
            s += int'(c[(8-k)*2 +: 2]) << (8 - k);
        fl = (s > 1023) || (s < 0);
        w  = (s > 1023) ? adc_fmt_pkg::CODE_POS_FS : (s < 0) ? adc_fmt_pkg::CODE_NEG_FS
                        : 10'(s);
        if (f == adc_fmt_pkg::FMT_TWOS)
            w[9] = ~w[9];
        return {~fl, fl, ~w, w};
    endfunction

    task automatic do_reset(input logic f, input logic h);
        @(negedge i_ref_clk);
        i_arst_n = 1'b0;
        fmt      = f;
        halve    = h;
        stall    = 1'b0;
        rx_u.got_q.delete();
        exp_q.delete();
        repeat (12) @(negedge i_ref_clk);
        check(32'({fwd_c, fwd_t, flag_c, flag_t, buf_ready, lost, word_c, word_t}),
              32'h02af_fc00);
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_ref_clk);
    endtask

    // one sampling clock period of 40 ns, i.e. 25 MHz
    task automatic edge_once(input logic [17:0] c, input logic comp_hi);
        code  = c;
        repeat (2) @(negedge i_ref_clk);
        clk_t = 1'b1;
        clk_c = comp_hi;
        repeat (2) @(negedge i_ref_clk);
        clk_t = 1'b0;
        clk_c = 1'b1;
    endtask

    task automatic run(input logic f, input logic h, input int ticks, input logic hold);
        int n;
        do_reset(f, h);
        stall = hold;
        // true leg rises while comp stays high: no sample may be taken
        edge_once(18'h3_ffff, 1'b1);
        for (int e = 0; e < ticks * (h ? 1 : 2); e++) begin
            edge_once(pick(e), 1'b0);
            if (h || e % 2 == 0)
                exp_q.push_back(expect_word(pick(e), f));
        end
        // a stalled receiver leaves eight stored words plus the buffer's output stage
        n = hold ? 9 : ticks - 9;
        if (hold) begin
            check(32'({buf_ready, lost}), 32'h0000_0001);
            stall = 1'b0;
        end
        for (int t = 0; t < 300 && rx_u.got_q.size() < n; t++)
            @(negedge i_ref_clk);
        repeat (20) @(negedge i_ref_clk);
        if (rx_u.got_q.size() < n) begin
            check(32'(rx_u.got_q.size()), 32'(n));
            wrap_up();
        end
        check(32'(rx_u.got_q.size()), 32'(n));
        for (int i = 0; i < n; i++)
            check(32'(rx_u.got_q[i]), 32'(exp_q[i]));
        check(32'({fwd_c, fwd_t, lost}), 32'({1'b1, 1'b0, hold}));
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        for (int m = 0; m < 4; m++)
            run(m[0], m[1], 20, 1'b0);
        run(1'b1, 1'b1, 24, 1'b1);
        wrap_up();
    end
endmodule
